/* pes_pkg.sv */
// Constants, types and register map of the precise exception sequencer
// Notes on behaviour
// - Synchronous exceptions are taken in program order despite out-of-order detection.
// - Only the oldest unfinished instruction may raise an exception that is taken.
// - At most one precise exception is reported at a time.
// - Several conditions on one instruction are served one by one, first detected first.
// - Detection positions one to five: trace, fetch check, I-bus break, emulation, FP off.
// - Position six holds five mutually exclusive causes; at most one per instruction; more are served in order and flagged.
// - Then FP assist (FPU or store), load/store check, FP assist on load, L-bus break.
// - Trace lets one instruction finish, then traps first on the next one.
// - Resume address names the restart point; older done, younger not done.
// - Resume address is the excepting instruction or the next, by cause.
// - Saved status is 32 bits, saved on exception; its lower half is restored into machine state on return.
// - Alignment faults record the offending data address in a 32-bit register.
// - Saved status upper half gets cause information, lower half machine state.
// - Reset clears machine state except the strapped prefix bit.
// - Every exception copies the exception-endian bit into the little-endian bit.
// - Vector is offset plus base zero, or 0xfff00000 when prefix bit set.
// - Machine state lower half is saved before the first handler instruction.
package pes_pkg;

  // Register map, byte addresses of 32-bit words
  localparam int              ADDR_W       = 8;
  localparam logic [ADDR_W-1:0] OFF_MSTATE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RESUME  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SAVED   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FAULT   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CAUSE   = 8'h1c;

  // Machine state bit indices; bit 0 of the big-endian numbering is index 31
  localparam int MS_ILE = 16;
  localparam int MS_EE  = 15;
  localparam int MS_ME  = 12;
  localparam int MS_SE  = 10;
  localparam int MS_IP  = 6;
  localparam int MS_LE  = 0;
  localparam int LOW_W  = 16;

  // Writable machine state bits; reserved bits stay zero
  localparam logic [31:0] MS_WMASK = 32'h0001ff73;
  localparam logic [31:0] MS_RESET = 32'h00000000;

  // Vector bases and spacing of vector offsets
  localparam logic [31:0] VEC_BASE_LO = 32'h00000000;
  localparam logic [31:0] VEC_BASE_HI = 32'hfff00000;
  localparam logic [31:0] VEC_STEP    = 32'h00000100;

  // Causes, numbered in detection order
  localparam int NCOND = 14;
  localparam int CW    = 4;
  localparam logic [CW-1:0] C_TRACE    = 4'h0;
  localparam logic [CW-1:0] C_MC_FETCH = 4'h1;
  localparam logic [CW-1:0] C_IBRK     = 4'h2;
  localparam logic [CW-1:0] C_EMUL     = 4'h3;
  localparam logic [CW-1:0] C_FP_OFF   = 4'h4;
  localparam logic [CW-1:0] C_PRIV     = 4'h5;
  localparam logic [CW-1:0] C_ALIGN    = 4'h6;
  localparam logic [CW-1:0] C_FP_EN    = 4'h7;
  localparam logic [CW-1:0] C_SYSCALL  = 4'h8;
  localparam logic [CW-1:0] C_TRAP     = 4'h9;
  localparam logic [CW-1:0] C_FPA_ST   = 4'ha;
  localparam logic [CW-1:0] C_MC_LS    = 4'hb;
  localparam logic [CW-1:0] C_FPA_LD   = 4'hc;
  localparam logic [CW-1:0] C_LBRK     = 4'hd;
  localparam int GRP6_LO = 5;
  localparam int GRP6_W  = 5;

  // Causes whose resume point is the following instruction
  localparam logic [NCOND-1:0] SAVE_NEXT = 14'h0100;

  // Interrupt status bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_TAKEN = 0;
  localparam int IRQ_RET   = 1;
  localparam int IRQ_MULTI = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } pes_state_t;

endpackage

/* pes_prio_pick.sv */
// Fixed priority picker: lowest set request index wins
`timescale 1ns/100ps
module pes_prio_pick #(
  parameter int N  = 14,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]  req,    // Request vector, index 0 highest
  output logic               found,  // Any request set
  output logic [IW-1:0]      idx     // Index of winner
);

  if (N < 2 || (1 << IW) < N) begin : g_chk
    $error("pes_prio_pick: index width cannot cover N");
  end

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end

endmodule

/* pes_top.sv */
// Precise exception sequencer with AXI4-Lite register access
`timescale 1ns/100ps
module pes_top (
  input  wire logic                     aclk,          // Core clock
  input  wire logic                     aresetn,       // Synchronous reset, low
  input  wire logic [pes_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input  wire logic                     s_axi_awvalid, // Write address valid
  output logic                          s_axi_awready, // Write address ready
  input  wire logic [31:0]              s_axi_wdata,   // Write data
  input  wire logic [3:0]               s_axi_wstrb,   // Write byte enables
  input  wire logic                     s_axi_wvalid,  // Write data valid
  output logic                          s_axi_wready,  // Write data ready
  output logic [1:0]                    s_axi_bresp,   // Write response
  output logic                          s_axi_bvalid,  // Write response valid
  input  wire logic                     s_axi_bready,  // Write response ready
  input  wire logic [pes_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input  wire logic                     s_axi_arvalid, // Read address valid
  output logic                          s_axi_arready, // Read address ready
  output logic [31:0]                   s_axi_rdata,   // Read data
  output logic [1:0]                    s_axi_rresp,   // Read response
  output logic                          s_axi_rvalid,  // Read data valid
  input  wire logic                     s_axi_rready,  // Read data ready
  input  wire logic                     head_valid,    // Oldest unretired instruction present
  input  wire logic [31:0]              head_pc,       // Its address
  input  wire logic [31:0]              head_next_pc,  // Address of the one after it
  input  wire logic [pes_pkg::NCOND-1:1] head_cond,    // Its detected conditions
  input  wire logic [15:0]              head_info,     // Cause specific status bits
  input  wire logic [31:0]              head_ea,       // Its data address
  input  wire logic                     head_retire,   // It retired without exception
  input  wire logic                     flush_ack,     // Pipeline flushed after take
  input  wire logic                     rfi_exec,      // Return from exception executes
  input  wire logic                     cfg_prefix,    // Config word prefix bit at reset
  output logic                          exc_take,      // Exception taken, pulse
  output logic [pes_pkg::CW-1:0]        exc_cause,     // Cause of that exception
  output logic [31:0]                   exc_vector,    // Handler fetch address
  output logic                          redirect,      // Return redirect, pulse
  output logic [31:0]                   redirect_pc,   // Return fetch address
  output logic                          le_mode,       // Little-endian mode bit
  output logic                          irq            // Level interrupt
);

  typedef struct packed {
    pes_pkg::pes_state_t            st;
    logic [31:0]                    machine_state;
    logic [31:0]                    resume_address_reg;
    logic [31:0]                    saved_machine_status;
    logic [31:0]                    fault_data_address;
    logic [pes_pkg::IRQ_W-1:0]      irq_st;
    logic [pes_pkg::IRQ_W-1:0]      irq_en;
    logic [pes_pkg::NCOND-1:0]      served;
    logic                           trace_pend;
    logic                           exc_take;
    logic [pes_pkg::CW-1:0]         exc_cause;
    logic [31:0]                    exc_vec;
    logic                           redir;
    logic [31:0]                    redir_pc;
    logic                           irq;
    logic                           aw_have;
    logic [pes_pkg::ADDR_W-1:0]     aw_addr;
    logic                           w_have;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic                           awready;
    logic                           wready;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arready;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
  } pes_regs_t;

  pes_regs_t s_r;
  pes_regs_t s_nxt;

  logic [pes_pkg::NCOND-1:0] avail;
  logic                      found;
  logic [pes_pkg::CW-1:0]    pick;
  logic                      take;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Trace sits at position one, ahead of all conditions of the same instruction
  assign avail = {head_cond, s_r.trace_pend} & ~s_r.served;

  pes_prio_pick #(
    .N  (pes_pkg::NCOND),
    .IW (pes_pkg::CW)
  ) u_pick (
    .req   (avail),
    .found (found),
    .idx   (pick)
  );

  // Only the head of the history buffer may trap, so older work is done first
  assign take = (s_r.st == pes_pkg::ST_RUN) && head_valid && found && !rfi_exec;

  always_comb begin
    logic [31:0]               base;
    logic [pes_pkg::ADDR_W-1:0] ra;
    base = '0;
    ra   = '0;
    s_nxt = s_r;
    s_nxt.exc_take = 1'b0;
    s_nxt.redir    = 1'b0;

    // Software register writes; hardware updates below override them
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = pes_pkg::RESP_OKAY;
      case (s_r.aw_addr)
        pes_pkg::OFF_MSTATE: begin
          s_nxt.machine_state = merge(s_r.machine_state, s_r.w_data, s_r.w_strb) & pes_pkg::MS_WMASK;
        end
        pes_pkg::OFF_RESUME: begin
          s_nxt.resume_address_reg = merge(s_r.resume_address_reg, s_r.w_data, s_r.w_strb);
        end
        pes_pkg::OFF_SAVED: begin
          s_nxt.saved_machine_status = merge(s_r.saved_machine_status, s_r.w_data, s_r.w_strb);
        end
        pes_pkg::OFF_FAULT: begin
          s_nxt.fault_data_address = merge(s_r.fault_data_address, s_r.w_data, s_r.w_strb);
        end
        pes_pkg::OFF_IRQ_EN: begin
          if (s_r.w_strb[0]) begin
            s_nxt.irq_en = s_r.w_data[pes_pkg::IRQ_W-1:0];
          end
        end
        pes_pkg::OFF_IRQ_CLR: begin
          if (s_r.w_strb[0]) begin
            s_nxt.irq_st = s_r.irq_st & ~s_r.w_data[pes_pkg::IRQ_W-1:0];
          end
        end
        pes_pkg::OFF_IRQ_ST, pes_pkg::OFF_CAUSE: begin
          s_nxt.bresp = pes_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = pes_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = {s_axi_awaddr[pes_pkg::ADDR_W-1:2], 2'b00};
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end

    // Register reads
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      ra = {s_axi_araddr[pes_pkg::ADDR_W-1:2], 2'b00};
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = pes_pkg::RESP_OKAY;
      case (ra)
        pes_pkg::OFF_MSTATE:  s_nxt.rdata = s_r.machine_state;
        pes_pkg::OFF_RESUME:  s_nxt.rdata = s_r.resume_address_reg;
        pes_pkg::OFF_SAVED:   s_nxt.rdata = s_r.saved_machine_status;
        pes_pkg::OFF_FAULT:   s_nxt.rdata = s_r.fault_data_address;
        pes_pkg::OFF_IRQ_ST:  s_nxt.rdata = 32'(s_r.irq_st);
        pes_pkg::OFF_IRQ_EN:  s_nxt.rdata = 32'(s_r.irq_en);
        pes_pkg::OFF_IRQ_CLR: s_nxt.rdata = 32'h00000000;
        pes_pkg::OFF_CAUSE:   s_nxt.rdata = {26'h0, s_r.st, s_r.exc_cause};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = pes_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Exception sequencing
    case (s_r.st)
      pes_pkg::ST_RUN: begin
        if (rfi_exec) begin
          s_nxt.machine_state[pes_pkg::LOW_W-1:0] = s_r.saved_machine_status[pes_pkg::LOW_W-1:0] &
                                          pes_pkg::MS_WMASK[pes_pkg::LOW_W-1:0];
          s_nxt.redir    = 1'b1;
          s_nxt.redir_pc = s_r.resume_address_reg;
          s_nxt.irq_st[pes_pkg::IRQ_RET] = 1'b1;
        end else if (take) begin
          s_nxt.st        = pes_pkg::ST_HOLD;
          s_nxt.exc_take  = 1'b1;
          s_nxt.exc_cause = pick;
          s_nxt.resume_address_reg      = pes_pkg::SAVE_NEXT[pick] ? head_next_pc : head_pc;
          s_nxt.saved_machine_status      = {head_info, s_r.machine_state[pes_pkg::LOW_W-1:0]};
          if (pick == pes_pkg::C_ALIGN) begin
            s_nxt.fault_data_address = head_ea;
          end
          s_nxt.machine_state[pes_pkg::MS_LE] = s_r.machine_state[pes_pkg::MS_ILE];
          base = s_r.machine_state[pes_pkg::MS_IP] ? pes_pkg::VEC_BASE_HI : pes_pkg::VEC_BASE_LO;
          s_nxt.exc_vec = base + pes_pkg::VEC_STEP * (32'(pick) + 32'h1);
          s_nxt.served[pick] = 1'b1;
          if (pick == pes_pkg::C_TRACE) begin
            s_nxt.trace_pend = 1'b0;
          end
          s_nxt.irq_st[pes_pkg::IRQ_TAKEN] = 1'b1;
        end else if (head_valid && head_retire) begin
          // Next instruction starts with a clean slate
          s_nxt.served = '0;
          // The instruction just finished ran untraced; the next one traps
          if (s_r.machine_state[pes_pkg::MS_SE]) begin
            s_nxt.trace_pend = 1'b1;
          end
        end
      end
      pes_pkg::ST_HOLD: begin
        // Nothing else is reported until the pipeline has flushed
        if (flush_ack) begin
          s_nxt.st = pes_pkg::ST_RUN;
        end
      end
      default: begin
        s_nxt.st = pes_pkg::ST_RUN;
      end
    endcase

    // Position six causes exclude each other; more than one is flagged
    if (head_valid && $countones(head_cond[pes_pkg::GRP6_LO +: pes_pkg::GRP6_W]) > 1) begin
      s_nxt.irq_st[pes_pkg::IRQ_MULTI] = 1'b1;
    end

    s_nxt.irq     = |(s_nxt.irq_st & s_nxt.irq_en);
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.st  = pes_pkg::ST_RUN;
      s_nxt.machine_state = pes_pkg::MS_RESET;
      // Prefix bit follows the strapped config word while reset is held
      s_nxt.machine_state[pes_pkg::MS_IP] = cfg_prefix;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign exc_take      = s_r.exc_take;
  assign exc_cause     = s_r.exc_cause;
  assign exc_vector    = s_r.exc_vec;
  assign redirect      = s_r.redir;
  assign redirect_pc   = s_r.redir_pc;
  assign le_mode       = s_r.machine_state[pes_pkg::MS_LE];
  assign irq           = s_r.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_take_head;
    exc_take |-> $past(head_valid) && $past(s_r.st) == pes_pkg::ST_RUN;
  endproperty
  a_take_head: assert property (p_take_head)
    else $error("exception taken without a head instruction");

  property p_one_at_time;
    exc_take |-> s_r.st == pes_pkg::ST_HOLD ##1 !exc_take;
  endproperty
  a_one_at_time: assert property (p_one_at_time)
    else $error("second exception reported while one is open");

  property p_first_detected;
    exc_take |-> ($past(avail) & ((14'h0001 << exc_cause) - 14'h0001)) == '0 &&
                 ($past(avail) & (14'h0001 << exc_cause)) != '0;
  endproperty
  a_first_detected: assert property (p_first_detected)
    else $error("taken cause is not the first detected");

  property p_trace_first;
    s_r.trace_pend && take |=> exc_take && exc_cause == pes_pkg::C_TRACE && !s_r.trace_pend;
  endproperty
  a_trace_first: assert property (p_trace_first)
    else $error("pending trace not taken first");

  property p_resume;
    exc_take |-> s_r.resume_address_reg == (pes_pkg::SAVE_NEXT[exc_cause] ? $past(head_next_pc) :
                              $past(head_pc));
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume address wrong for cause");

  property p_saved_low;
    exc_take |-> s_r.saved_machine_status[15:0] == $past(s_r.machine_state[15:0]) && s_r.saved_machine_status[31:16] == $past(head_info);
  endproperty
  a_saved_low: assert property (p_saved_low)
    else $error("saved status halves wrong");

  property p_endian;
    exc_take |-> le_mode == $past(s_r.machine_state[pes_pkg::MS_ILE]);
  endproperty
  a_endian: assert property (p_endian)
    else $error("little-endian bit not copied on exception");

  property p_fault_addr;
    exc_take && exc_cause == pes_pkg::C_ALIGN |-> s_r.fault_data_address == $past(head_ea);
  endproperty
  a_fault_addr: assert property (p_fault_addr)
    else $error("fault address not recorded");

  property p_vector;
    exc_take |-> exc_vector == (($past(s_r.machine_state[pes_pkg::MS_IP]) ? 32'hfff00000 : 32'h0) +
                                32'h100 * (32'(exc_cause) + 32'h1));
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector base or offset wrong");

  property p_return;
    rfi_exec && s_r.st == pes_pkg::ST_RUN |=>
      redirect && redirect_pc == $past(s_r.resume_address_reg) &&
      s_r.machine_state[15:0] == ($past(s_r.saved_machine_status[15:0]) & 16'hff73);
  endproperty
  a_return: assert property (p_return)
    else $error("return did not restore state or resume");

  property p_reset_state;
    $past(!aresetn) |-> (s_r.machine_state & ~32'h00000040) == 32'h0 && !exc_take && !irq;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("machine state not cleared by reset");

  property p_multi6;
    head_valid && $countones(head_cond[9:5]) > 1 |=> s_r.irq_st[pes_pkg::IRQ_MULTI];
  endproperty
  a_multi6: assert property (p_multi6)
    else $error("several position six causes not flagged");

endmodule

/* pes_pipe_model.sv */
// Pipeline head model that feeds the exception sequencer
`timescale 1ns/100ps
module pes_pipe_model (
  input  wire logic        aclk,         // Core clock
  input  wire logic        aresetn,      // Reset, low
  input  wire logic        load,         // New head instruction
  input  wire logic [13:1] ld_cond,      // Its conditions
  input  wire logic [31:0] ld_pc,        // Its address
  input  wire logic [31:0] ld_ea,        // Its data address
  input  wire logic [15:0] ld_info,      // Its cause info
  input  wire logic        retire_req,   // Retire head once flushed
  input  wire logic        hold,         // Stall the flush answer
  input  wire logic        exc_take,     // Exception taken
  output logic             head_valid,   // Head present
  output logic [31:0]      head_pc,      // Head address
  output logic [31:0]      head_next_pc, // Following address
  output logic [13:1]      head_cond,    // Head conditions
  output logic [15:0]      head_info,    // Cause info
  output logic [31:0]      head_ea,      // Data address
  output logic             head_retire,  // Retire pulse
  output logic             flush_ack     // Flush done pulse
);
  logic        vld_r;
  logic        pend_r;
  logic [31:0] pc_r;
  logic [31:0] ea_r;
  logic [13:1] cond_r;
  logic [15:0] info_r;
  // Released fields show inverted data so stale values cannot pass
  assign head_valid   = vld_r;
  assign head_pc      = vld_r ? pc_r : ~pc_r;
  assign head_next_pc = vld_r ? pc_r + 32'h4 : ~(pc_r + 32'h4);
  assign head_cond    = vld_r ? cond_r : ~cond_r;
  assign head_info    = vld_r ? info_r : ~info_r;
  assign head_ea      = vld_r ? ea_r : ~ea_r;
  always_ff @(posedge aclk) begin
    head_retire <= 1'h0;
    flush_ack <= 1'h0;
    if (!aresetn) begin
      vld_r <= 1'h0;
      pend_r <= 1'h0;
    end else begin
      if (exc_take) begin
        pend_r <= 1'h1;
      end else if (pend_r && !hold) begin
        flush_ack <= 1'h1;
        pend_r <= 1'h0;
      end
      if (load) begin
        vld_r <= 1'h1;
        cond_r <= ld_cond;
        pc_r <= ld_pc;
        ea_r <= ld_ea;
        info_r <= ld_info;
      end else if (head_retire) begin
        // Head stays valid through its retire pulse, then leaves
        vld_r <= 1'h0;
      end else if (retire_req && vld_r && !pend_r) begin
        // Head leaves only after its exceptions are flushed
        head_retire <= 1'h1;
      end
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the precise exception sequencer
`timescale 1ns/100ps
module tb_top;
  logic        aclk = 0, aresetn = 0, cfg_prefix = 1, rfi_exec = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, ld_pc = 0, ld_ea = 0;
  logic [3:0]  s_axi_wstrb = 4'hf, exc_cause;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        head_valid, head_retire, flush_ack, exc_take, redirect, le_mode, irq;
  logic [31:0] head_pc, head_next_pc, head_ea, exc_vector, redirect_pc;
  logic [13:1] head_cond, ld_cond = 0;
  logic [15:0] head_info, ld_info = 0;
  logic        load = 0, retire_req = 0, hold = 0, trc = 0;
  logic [31:0] ms, res, sav, flt, seed = 32'hfaf691e3, d, v;
  logic [1:0]  r;
  int          n_fail = 0, checked = 0, n_take = 0, exp_take = 0, cyc = 0;

  pes_top u_pes_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .head_valid, .head_pc, .head_next_pc, .head_cond,
    .head_info, .head_ea, .head_retire, .flush_ack, .rfi_exec, .cfg_prefix, .exc_take,
    .exc_cause, .exc_vector, .redirect, .redirect_pc, .le_mode, .irq);
  pes_pipe_model u_pes_pipe_model (.aclk, .aresetn, .load, .ld_cond, .ld_pc, .ld_ea,
    .ld_info, .retire_req, .hold, .exc_take, .head_valid, .head_pc, .head_next_pc,
    .head_cond, .head_info, .head_ea, .head_retire, .flush_ack);

  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (exc_take === 1'h1) n_take++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] dv);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wms(input logic [31:0] nv);
    axw(pes_pkg::OFF_MSTATE, nv);
    ms = nv & pes_pkg::MS_WMASK;
  endtask
  // Bounded wait for a pulse: 0 take, 1 redirect, 2 retire
  task automatic wt(input int which);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((which == 0 ? exc_take : which == 1 ? redirect : head_retire) !== 1'h1
               && n < 60);
    chk(n < 60, 1);
  endtask
  task automatic run_instr(input logic [13:1] c);
    logic [31:0] pc, ea;
    pc = rnd() & 32'hfffffffc;
    ea = rnd();
    v = rnd();
    @(posedge aclk);
    load <= 1;
    ld_cond <= c;
    ld_pc <= pc;
    ld_ea <= ea;
    ld_info <= v[15:0];
    hold <= 1;
    @(posedge aclk);
    load <= 0;
    for (int k = 0; k < 14; k++) begin
      if (k == 0 ? trc : c[k]) begin
        wt(0);
        exp_take++;
        sav = {v[15:0], ms[15:0]};
        res = (k == 8) ? pc + 32'h4 : pc;
        if (k == 6) flt = ea;
        ms[0] = ms[16];
        chk(exc_cause, k);
        chk(exc_vector, (ms[6] ? 32'hfff00000 : 32'h0) + 32'h100 * (k + 1));
        chk(le_mode, ms[0]);
        axr(pes_pkg::OFF_RESUME);
        chk(d, res);
        axr(pes_pkg::OFF_SAVED);
        chk(d, sav);
        axr(pes_pkg::OFF_FAULT);
        chk(d, flt);
        hold <= 0;
        @(posedge aclk);
        hold <= 1;
      end
    end
    @(posedge aclk);
    hold <= 0;
    retire_req <= 1;
    trc = 0;
    wt(2);
    retire_req <= 0;
    trc = ms[pes_pkg::MS_SE];
  endtask
  task automatic summarize();
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    axr(pes_pkg::OFF_MSTATE);
    chk(d, 32'h40);
    ms = 32'h40;
    flt = 0;
    axw(pes_pkg::OFF_IRQ_EN, 32'h1);
    for (int k = 1; k < 14; k++) run_instr(13'h1 << (k - 1));
    chk(irq, 1);
    axw(pes_pkg::OFF_IRQ_CLR, 32'h7);
    chk(irq, 0);
    axw(pes_pkg::OFF_IRQ_EN, 32'h0);
    wms(32'h00010000);
    // Random mixes with exactly one position-six cause
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      run_instr((v[12:0] & 13'h1e0f) | (13'h1 << (4 + v[20:16] % 5)));
    end
    // Two position-six causes on one head must raise the status flag
    run_instr(13'h0a0);
    axr(pes_pkg::OFF_IRQ_ST);
    chk(d, 32'h5);
    chk(irq, 0);
    wms(32'h00010400);
    run_instr(13'h0);
    run_instr(13'h4);
    sav = rnd();
    axw(pes_pkg::OFF_SAVED, sav);
    @(posedge aclk);
    rfi_exec <= 1;
    @(posedge aclk);
    rfi_exec <= 0;
    wt(1);
    ms[15:0] = sav[15:0] & 16'hff73;
    chk(redirect_pc, res);
    chk(le_mode, ms[0]);
    axr(pes_pkg::OFF_MSTATE);
    chk(d, ms);
    axr(pes_pkg::OFF_IRQ_ST);
    chk(d, 32'h7);
    axr(pes_pkg::OFF_CAUSE);
    chk(d, 32'h13);
    axw(8'h20, 32'h1);
    chk(r, pes_pkg::RESP_SLVERR);
    axr(8'h20);
    chk(r, pes_pkg::RESP_SLVERR);
    chk(n_take, exp_take);
    summarize();
  end
endmodule
